//--- dv/hgcb_csr_bank_test.sv
// Self-checking bench for the guest CSR bank
module hgcb_csr_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import hgcb_pkg::*;

  localparam int unsigned GIC   = 8;
  localparam logic [31:0] CMASK = 32'hffff_fffa; // Cycle and retired bits hardwired low
  localparam logic [63:0] EMASK = ((64'h1 << (GIC + 1)) - 64'h1) & ~64'h1;
  localparam logic [63:0] TOFS  = 64'hffff_ffff_ffff_fff0; // Acts as minus sixteen

  logic         clk, rst, cyc, stb, we, ack, err, virt, vu, amo_io, amo_aq, rd_req;
  logic         summ, vsp, iofm, pbm, adu, amo_o, permit, fault;
  logic [7:0]   adr;
  logic [3:0]   sel, fio, fmem, fmem_o;
  logic [31:0]  wdat, rdat, mach, sup, gw;
  logic [5:0]   vsel;
  logic [4:0]   cidx;
  logic [127:0] req;
  logic [63:0]  lines, tim, gtime, en, pend;
  int           miscompares, checks_done, seed;
  logic [7:0]   zofs [6];

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  hgcb_irq_ctrl_model ctrl (.clk_i(clk), .dev_req_i(req), .lines_o(lines));

  hgcb_csr_bank #(.GUEST_IRQ_COUNT(GIC), .COUNTER_IMPL_MASK(CMASK)) dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .guest_irq_lines_i(lines),
    .vs_guest_irq_select_i(vsel), .virt_mode_i(virt), .vu_mode_i(vu),
    .hs_guest_irq_summary_o(summ), .vs_external_pending_o(vsp),
    .fence_io_set_i(fio), .fence_mem_set_i(fmem), .amo_io_region_i(amo_io),
    .amo_aq_rl_i(amo_aq), .fence_mem_set_o(fmem_o), .amo_order_memory_o(amo_o),
    .io_fence_implies_memory_o(iofm), .page_memtype_enable_o(pbm),
    .hw_access_dirty_update_enable_o(adu), .counter_read_i(rd_req),
    .counter_index_i(cidx), .mach_counter_enable_i(mach), .sup_counter_enable_i(sup),
    .counter_read_permit_o(permit), .virt_instr_fault_o(fault), .time_i(tim),
    .guest_time_o(gtime));

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; the request is held until ack or err is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic x_err, input logic [31:0] x_dat);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // No answer time is assumed; only the watchdog ends a wait that hangs
    do
      @(posedge clk);
    while (ack !== 1'b1 && err !== 1'b1);
    check(ack ^ err, 1'b1);
    check(err, x_err);
    if (!w)
      check(rdat, x_dat);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb

  // Controller folding of device requests
  function automatic logic [63:0] exp_lines(input logic [127:0] r);
    logic [63:0] s;
    for (int v = 0; v < 64; v++)
      s[v] = r[2*v] | r[2*v+1];
    return s;
  endfunction : exp_lines

  // Counter decision as {permit, fault}
  function automatic logic [1:0] exp_cnt(input logic [4:0] i, input logic v, input logic u,
                                         input logic [31:0] m, input logic [31:0] g,
                                         input logic [31:0] s);
    logic ok;
    ok = g[i] & CMASK[i] & (~u | s[i]);
    if (!v)
      return {m[i], 1'b0};
    return {m[i] & ok, m[i] & ~ok};
  endfunction : exp_cnt

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // Watchdog, far beyond the roughly 1000 cycles the sequence needs
  initial
  begin
    #200000;
    miscompares++;
    summarize();
  end

  // Main sequence
  initial
  begin
    seed = 32'h46d992a7;
    {rst, cyc, stb, we, virt, vu, amo_io, amo_aq, rd_req} = 9'h100;
    {adr, fio, fmem, wdat, mach, sup, vsel, cidx, req, tim} = '0;
    sel = 4'hf;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Enable, configuration, low time offset and counter enable read zero out of reset
    zofs = '{OFS_EN_LO, OFS_EN_UP, OFS_ENV_LO, OFS_ENV_UP, OFS_TOFS_LO, OFS_CNTEN};
    foreach (zofs[k])
      wb(1'b0, zofs[k], 0, 0, 0);
    // Aliases are absent at 64-bit width, as is anything past the map
    wb(1'b1, OFS_ENV_HIGH, 32'hffff_ffff, 1'b1, 0);
    wb(1'b0, OFS_TOFS_HIGH, 0, 1'b1, 0);
    wb(1'b0, 8'h40, 0, 1'b1, 0);
    // Only enable bits count down to 1 hold ones
    wb(1'b1, OFS_EN_LO, 32'hffff_ffff, 0, 0);
    wb(1'b1, OFS_EN_UP, 32'hffff_ffff, 0, 0);
    wb(1'b0, OFS_EN_LO, 0, 0, EMASK[31:0]);
    wb(1'b0, OFS_EN_UP, 0, 0, EMASK[63:32]);
    // Undefined configuration fields drop writes
    wb(1'b1, OFS_ENV_LO, 32'hffff_ffff, 0, 0);
    wb(1'b1, OFS_ENV_UP, 32'hffff_ffff, 0, 0);
    wb(1'b0, OFS_ENV_LO, 0, 0, 32'h1);
    wb(1'b0, OFS_ENV_UP, 0, 0, 32'h6000_0000);
    wb(1'b1, OFS_TOFS_LO, TOFS[31:0], 0, 0);
    wb(1'b1, OFS_TOFS_UP, TOFS[63:32], 0, 0);
    wb(1'b0, OFS_TOFS_UP, 0, 0, TOFS[63:32]);
    // A single byte lane lands; the others keep their reset zeros
    sel <= 4'h2;
    wb(1'b1, OFS_CNTEN, 32'hffff_ffff, 0, 0);
    sel <= 4'hf;
    wb(1'b0, OFS_CNTEN, 0, 0, 32'h0000_ff00 & CMASK);
    // Random traffic with corner cases in the first rounds
    for (int t = 0; t < 40; t++)
    begin
      // Round 0: nothing enabled, all lines up; round 1: bit 0 selected, time wraps
      en   = (t == 0) ? 64'h0 : {$random(seed), $random(seed)};
      gw   = $random(seed);
      req  <= (t < 2) ? {128{1'b1}}
                      : {$random(seed), $random(seed), $random(seed), $random(seed)};
      vsel <= (t == 0) ? 6'h3 : ((t == 1) ? 6'h0 : 6'($random(seed)));
      tim  <= (t == 1) ? 64'h5 : {$random(seed), $random(seed)};
      wb(1'b1, OFS_EN_LO, en[31:0], 0, 0);
      wb(1'b1, OFS_EN_UP, en[63:32], 0, 0);
      wb(1'b1, OFS_CNTEN, gw, 0, 0);
      wb(1'b1, OFS_PEND_LO, 32'hffff_ffff, 0, 0);
      {virt, amo_io, amo_aq, rd_req, fio, fmem} <= 12'($random(seed));
      vu <= t[0] ? 1'($random(seed)) : 1'b0;
      {mach, sup, cidx} <= {$random(seed), $random(seed), 5'($random(seed))};
      repeat (4) @(posedge clk);
      pend = exp_lines(req) & EMASK;
      check(summ, |(pend & en));
      check(vsp, pend[vsel]);
      check(fmem_o, fmem | (virt ? fio : 4'h0));
      check(amo_o, amo_io & amo_aq & virt);
      check({iofm, pbm, adu}, {3{virt}});
      check(gtime, virt ? tim + TOFS : tim);
      check({permit, fault}, rd_req ? exp_cnt(cidx, virt, vu & virt, mach, gw, sup) : 2'b00);
      wb(1'b0, OFS_CNTEN, 0, 0, gw & CMASK);
      wb(1'b0, OFS_PEND_LO, 0, 0, pend[31:0]);
      wb(1'b0, OFS_PEND_UP, 0, 0, pend[63:32]);
    end
    summarize();
  end
endmodule : hgcb_csr_bank_test

//--- dv/hgcb_irq_ctrl_model.sv
// Interrupt controller model: folds device requests into per-virtual-hart lines
module hgcb_irq_ctrl_model
(
  // Clock
  input  wire logic [0:0]   clk_i,
  // Device requests, two for each virtual hart
  input  wire logic [127:0] dev_req_i,
  // Per-virtual-hart summary lines
  output logic      [63:0]  lines_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [63:0] sum_next;

  // Bit 0 and unused lines are driven too, so the bank must mask them itself
  always_comb
  begin
    for (int v = 0; v < 64; v++)
      sum_next[v] = |dev_req_i[2*v +: 2];
  end

  // Registered like a real controller, which adds one cycle of latency
  always_ff @(posedge clk_i)
    lines_o <= sum_next;
endmodule : hgcb_irq_ctrl_model

//--- src/hgcb_counter_gate.sv
// Guest counter read permission and virtual-instruction fault
module hgcb_counter_gate
  import hgcb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Read request from the pipeline
  input  wire logic        read_i,
  input  wire logic [4:0]  index_i,
  input  wire logic        virt_i,
  input  wire logic        vu_i,
  // Enable vectors of three levels
  input  wire logic [31:0] mach_en_i,
  input  wire logic [31:0] guest_en_i,
  input  wire logic [31:0] sup_en_i,
  // Decision
  output logic             permit_o,
  output logic             fault_o
);
  wire logic m_bit = mach_en_i[index_i];
  wire logic h_bit = guest_en_i[index_i];
  wire logic s_bit = sup_en_i[index_i];
  // Machine-level refusal is another trap and is left to the core
  wire logic guest_ok = h_bit & (!vu_i | s_bit);
  wire logic permit   = read_i & m_bit & (!virt_i | guest_ok);
  wire logic fault    = read_i & virt_i & m_bit & !guest_ok;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      permit_o <= 1'b0;
      fault_o  <= 1'b0;
    end
    else
    begin
      permit_o <= permit;
      fault_o  <= fault;
    end
  end

  a_vu_needs_both: assert property (@(posedge clk_i) disable iff (rst_i)
    read_i && virt_i && vu_i && m_bit && !s_bit |=> fault_o && !permit_o)
    else $error("vu read without supervisor bit");
endmodule : hgcb_counter_gate

//--- src/hgcb_csr_bank.sv
// Hypervisor guest CSR bank for one hart, reached over classic Wishbone
module hgcb_csr_bank
  import hgcb_pkg::*;
#(
  parameter int unsigned HYP_WORD_WIDTH    = 64,
  parameter int unsigned GUEST_IRQ_COUNT   = 8,
  parameter bit          PBMT_PRESENT      = 1'b1,
  parameter bit          ADU_PRESENT       = 1'b1,
  parameter logic [31:0] COUNTER_IMPL_MASK = 32'hffff_ffff
)(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [HGCB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  // Interrupt controller and hart status
  input  wire logic [63:0]           guest_irq_lines_i,
  input  wire logic [5:0]            vs_guest_irq_select_i,
  input  wire logic                  virt_mode_i,
  input  wire logic                  vu_mode_i,
  output logic                       hs_guest_irq_summary_o,
  output logic                       vs_external_pending_o,
  // Fence and atomic ordering, sets as {in/read pred, out/write pred, in succ, out succ}
  input  wire logic [3:0]            fence_io_set_i,
  input  wire logic [3:0]            fence_mem_set_i,
  input  wire logic                  amo_io_region_i,
  input  wire logic                  amo_aq_rl_i,
  output logic [3:0]                 fence_mem_set_o,
  output logic                       amo_order_memory_o,
  output logic                       io_fence_implies_memory_o,
  // Translation controls
  output logic                       page_memtype_enable_o,
  output logic                       hw_access_dirty_update_enable_o,
  // Counter access
  input  wire logic                  counter_read_i,
  input  wire logic [4:0]            counter_index_i,
  input  wire logic [31:0]           mach_counter_enable_i,
  input  wire logic [31:0]           sup_counter_enable_i,
  output logic                       counter_read_permit_o,
  output logic                       virt_instr_fault_o,
  // Time
  input  wire logic [63:0]           time_i,
  output logic [63:0]                guest_time_o
);
  // Capacity cap by word width
  localparam int unsigned MAX_GIC = (HYP_WORD_WIDTH == HGCB_HYP_W32) ?
                                    HGCB_MAX_GIC_32 : HGCB_MAX_GIC_64;
  localparam int unsigned GIC     = (GUEST_IRQ_COUNT > MAX_GIC) ?
                                    MAX_GIC : GUEST_IRQ_COUNT;
  localparam logic [6:0]  GIC_TOP = 7'(GIC + 1);
  // Bits count..1 live, bit 0 and everything above read zero
  localparam logic [63:0] IRQ_MASK = ((64'h1 << GIC_TOP) - 64'h1) & ~64'h1;
  localparam bit          HAS_ALIAS = (HYP_WORD_WIDTH == HGCB_HYP_W32);
  // Only the fence, page type and A/D bits are stored; the rest read zero
  localparam logic [63:0] ENV_WMASK = (64'h1 << ENV_IO_FENCE_BIT)
                                    | ({63'h0, PBMT_PRESENT} << ENV_PAGE_TYPE_BIT)
                                    | ({63'h0, ADU_PRESENT} << ENV_HW_AD_BIT);

  // Registers
  logic [63:0] en_reg;
  logic [63:0] en_next;
  logic [63:0] env_reg;
  logic [63:0] env_next;
  logic [63:0] tofs_reg;
  logic [63:0] tofs_next;
  logic [31:0] cnten_reg;
  logic [31:0] cnten_next;
  logic [31:0] dat_reg;
  logic        ack_reg;
  logic        err_reg;
  logic [63:0] time_reg;
  logic [3:0]  fence_reg;
  logic        amo_reg;
  logic        io_fence_reg;
  logic        memtype_reg;
  logic        ad_upd_reg;
  logic [63:0] pending;

  // Bus decode; a new request is taken only while no answer is showing
  wire logic req        = wb_cyc_i & wb_stb_i & !ack_reg & !err_reg;
  wire logic wr         = req & wb_we_i;
  wire logic hit_pnd_lo = (wb_adr_i == OFS_PEND_LO);
  wire logic hit_pnd_up = (wb_adr_i == OFS_PEND_UP);
  wire logic hit_en_lo  = (wb_adr_i == OFS_EN_LO);
  wire logic hit_en_up  = (wb_adr_i == OFS_EN_UP);
  wire logic hit_env_lo = (wb_adr_i == OFS_ENV_LO);
  wire logic hit_env_up = (wb_adr_i == OFS_ENV_UP)
                        | (HAS_ALIAS && (wb_adr_i == OFS_ENV_HIGH));
  wire logic hit_tof_lo = (wb_adr_i == OFS_TOFS_LO);
  wire logic hit_tof_up = (wb_adr_i == OFS_TOFS_UP)
                        | (HAS_ALIAS && (wb_adr_i == OFS_TOFS_HIGH));
  wire logic hit_cnten  = (wb_adr_i == OFS_CNTEN);
  wire logic mapped     = hit_pnd_lo | hit_pnd_up | hit_en_lo | hit_en_up
                        | hit_env_lo | hit_env_up | hit_tof_lo | hit_tof_up
                        | hit_cnten;

  // Write paths; pending has none, so writes to it are simply dropped
  assign en_next[31:0]    = (wr && hit_en_lo) ?
                            hgcb_merge(en_reg[31:0], wb_dat_i, wb_sel_i) : en_reg[31:0];
  assign en_next[63:32]   = (wr && hit_en_up) ?
                            hgcb_merge(en_reg[63:32], wb_dat_i, wb_sel_i) : en_reg[63:32];
  assign env_next[31:0]   = (wr && hit_env_lo) ?
                            hgcb_merge(env_reg[31:0], wb_dat_i, wb_sel_i) : env_reg[31:0];
  assign env_next[63:32]  = (wr && hit_env_up) ?
                            hgcb_merge(env_reg[63:32], wb_dat_i, wb_sel_i) : env_reg[63:32];
  assign tofs_next[31:0]  = (wr && hit_tof_lo) ?
                            hgcb_merge(tofs_reg[31:0], wb_dat_i, wb_sel_i) : tofs_reg[31:0];
  assign tofs_next[63:32] = (wr && hit_tof_up) ?
                            hgcb_merge(tofs_reg[63:32], wb_dat_i, wb_sel_i) : tofs_reg[63:32];
  assign cnten_next       = (wr && hit_cnten) ?
                            hgcb_merge(cnten_reg, wb_dat_i, wb_sel_i) : cnten_reg;

  // Read mux, AND-OR so unmapped lanes fall to zero
  wire logic [31:0] rd_word = ({32{hit_pnd_lo}} & pending[31:0])
                            | ({32{hit_pnd_up}} & pending[63:32])
                            | ({32{hit_en_lo}}  & en_reg[31:0])
                            | ({32{hit_en_up}}  & en_reg[63:32])
                            | ({32{hit_env_lo}} & env_reg[31:0])
                            | ({32{hit_env_up}} & env_reg[63:32])
                            | ({32{hit_tof_lo}} & tofs_reg[31:0])
                            | ({32{hit_tof_up}} & tofs_reg[63:32])
                            | ({32{hit_cnten}}  & cnten_reg);

  // Register storage; masks applied on the way in keep dead bits at zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_reg    <= RST_EN;
      env_reg   <= RST_ENV;
      tofs_reg  <= RST_TOFS;
      cnten_reg <= RST_CNTEN;
    end
    else
    begin
      en_reg    <= en_next & IRQ_MASK;
      env_reg   <= env_next & ENV_WMASK;
      tofs_reg  <= tofs_next;
      cnten_reg <= cnten_next & COUNTER_IMPL_MASK;
    end
  end

  // Bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      dat_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= req & mapped;
      err_reg <= req & !mapped;
      dat_reg <= (req && !wb_we_i && mapped) ? rd_word : 32'h0;
    end
  end

  // Environment effects apply only in virtualization mode
  wire logic io_fence_act = virt_mode_i & env_reg[ENV_IO_FENCE_BIT];
  wire logic [3:0] fence_eff = fence_mem_set_i | (io_fence_act ? fence_io_set_i : 4'h0);
  wire logic amo_eff   = amo_io_region_i & amo_aq_rl_i & io_fence_act;

  // Hart-facing outputs, all registered; the time sum wraps on purpose
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      time_reg  <= 64'h0;
      fence_reg <= 4'h0;
      amo_reg   <= 1'b0;
      io_fence_reg <= 1'b0;
      memtype_reg  <= 1'b0;
      ad_upd_reg   <= 1'b0;
    end
    else
    begin
      time_reg  <= virt_mode_i ? (time_i + tofs_reg) : time_i;
      fence_reg <= fence_eff;
      amo_reg   <= amo_eff;
      io_fence_reg <= io_fence_act;
      memtype_reg  <= virt_mode_i & env_reg[ENV_PAGE_TYPE_BIT];
      ad_upd_reg   <= virt_mode_i & env_reg[ENV_HW_AD_BIT];
    end
  end

  hgcb_guest_irq #(
    .IRQ_MASK (IRQ_MASK)
  ) u_guest_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .lines_i   (guest_irq_lines_i),
    .enable_i  (en_reg),
    .select_i  (vs_guest_irq_select_i),
    .pending_o (pending),
    .summary_o (hs_guest_irq_summary_o),
    .vs_pend_o (vs_external_pending_o)
  );

  hgcb_counter_gate u_counter_gate (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .read_i     (counter_read_i),
    .index_i    (counter_index_i),
    .virt_i     (virt_mode_i),
    .vu_i       (vu_mode_i),
    .mach_en_i  (mach_counter_enable_i),
    .guest_en_i (cnten_reg),
    .sup_en_i   (sup_counter_enable_i),
    .permit_o   (counter_read_permit_o),
    .fault_o    (virt_instr_fault_o)
  );

  assign wb_dat_o                        = dat_reg;
  assign wb_ack_o                        = ack_reg;
  assign wb_err_o                        = err_reg;
  assign guest_time_o                    = time_reg;
  assign fence_mem_set_o                 = fence_reg;
  assign amo_order_memory_o              = amo_reg;
  assign io_fence_implies_memory_o       = io_fence_reg;
  assign page_memtype_enable_o           = memtype_reg;
  assign hw_access_dirty_update_enable_o = ad_upd_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && mapped;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_once: assert property (s_req_taken |=> s_ack_pulse)
    else $error("ack not a single pulse");
  a_summary_and: assert property (##1 hs_guest_irq_summary_o
                                  == |($past(pending) & $past(en_reg)))
    else $error("summary disagrees with pending and enable");
  a_enable_mask: assert property ((en_reg & ~IRQ_MASK) == 64'h0)
    else $error("enable bit outside live range");
  a_time_offset: assert property (virt_mode_i
                                  |=> guest_time_o == $past(time_i) + $past(tofs_reg))
    else $error("guest time not offset");
  a_time_plain: assert property (!virt_mode_i |=> guest_time_o == $past(time_i))
    else $error("host time altered");
  a_env_reserved: assert property ((env_reg & ~ENV_WMASK) == 64'h0)
    else $error("reserved config bit set");
  a_fence_widen: assert property (virt_mode_i && env_reg[ENV_IO_FENCE_BIT]
                                  |=> fence_mem_set_o
                                      == ($past(fence_io_set_i) | $past(fence_mem_set_i)))
    else $error("fence not widened");
  a_cnt_trap: assert property (counter_read_i && virt_mode_i
                               && mach_counter_enable_i[counter_index_i]
                               && !cnten_reg[counter_index_i] |=> virt_instr_fault_o)
    else $error("counter read not trapped");
  a_cnten_write: assert property ((s_req_taken and (wb_we_i && hit_cnten && wb_sel_i == 4'hf))
                                  |=> cnten_reg == ($past(wb_dat_i) & COUNTER_IMPL_MASK))
    else $error("counter enable write lost");
endmodule : hgcb_csr_bank

//--- src/hgcb_guest_irq.sv
// Guest interrupt pending capture, HS summary and VS source selection
module hgcb_guest_irq
  import hgcb_pkg::*;
#(
  parameter logic [63:0] IRQ_MASK = 64'h0
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Controller lines and control
  input  wire logic [63:0] lines_i,
  input  wire logic [63:0] enable_i,
  input  wire logic [5:0]  select_i,
  // Results
  output logic [63:0]      pending_o,
  output logic             summary_o,
  output logic             vs_pend_o
);
  logic [63:0] pend_reg;
  logic        summary_reg;
  logic        vs_reg;
  wire  logic  any_enabled = |(pend_reg & enable_i);

  // Pending bits only follow the controller; no bus path reaches them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_reg    <= 64'h0;
      summary_reg <= 1'b0;
      vs_reg      <= 1'b0;
    end
    else
    begin
      pend_reg    <= lines_i & IRQ_MASK;
      summary_reg <= any_enabled;
      vs_reg      <= pend_reg[select_i];
    end
  end

  assign pending_o = pend_reg;
  assign summary_o = summary_reg;
  assign vs_pend_o = vs_reg;

  a_pend_sampled: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 pend_reg == ($past(lines_i) & IRQ_MASK)) else $error("pending not sampled");
  a_pend_bit0: assert property (@(posedge clk_i) disable iff (rst_i)
    !pend_reg[0]) else $error("pending bit 0 set");
  a_vs_select: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 vs_reg == |($past(pend_reg) & (64'h1 << $past(select_i))))
    else $error("vs source wrong");
endmodule : hgcb_guest_irq

//--- src/hgcb_pkg.sv
// How it works
// - Guest interrupt pending register is read-only, one hypervisor word wide.
// - Each pending bit summarizes one virtual hart; same index selects its enable.
// - Guest interrupt bit count is configurable, may be zero, never uses bit 0.
// - Enable bits count down to 1 writable; all other positions read zero.
// - Guest interrupt count is capped at 31 or 63 by word width.
// - Enable vector selects which pending bits raise the HS guest interrupt.
// - VS external source picked by the select field ignores the enable vector.
// - HS guest summary is one exactly when pending AND enable is nonzero.
// - VS external pending term is the pending bit indexed by the select field.
// - 64-bit environment configuration acts only while virtualization mode is on.
// - Bit 0 with virtualization makes fence I/O bits also cover memory.
// - Same setting orders acquire/release atomics to I/O regions as memory too.
// - Bit 62 enables page memory types; reads zero when the feature is absent.
// - Bit 61 enables hardware A/D updates, else they fault; zero if unsupported.
// - With 32-bit words, upper halves appear in alias registers; absent at 64 bits.
// - Clear counter bit with machine bit set traps guest counter reads.
// - Set counter bit permits the guest counter read unless blocked elsewhere.
// - In VU-mode both guest and supervisor counter bits must be set.
// - Counter-enable always exists; hardwired-zero bits make guest reads trap.
// - Guest time reads return real time plus the 64-bit offset.
// - Carry out of the time offset sum is dropped.
package hgcb_pkg;
  localparam int unsigned HGCB_ADR_W      = 8;
  localparam int unsigned HGCB_HYP_W32    = 32;
  localparam int unsigned HGCB_MAX_GIC_32 = 31;
  localparam int unsigned HGCB_MAX_GIC_64 = 63;
  // Register byte offsets
  localparam logic [7:0] OFS_PEND_LO   = 8'h00;
  localparam logic [7:0] OFS_PEND_UP   = 8'h04;
  localparam logic [7:0] OFS_EN_LO     = 8'h08;
  localparam logic [7:0] OFS_EN_UP     = 8'h0c;
  localparam logic [7:0] OFS_ENV_LO    = 8'h10;
  localparam logic [7:0] OFS_ENV_UP    = 8'h14;
  localparam logic [7:0] OFS_ENV_HIGH  = 8'h18;
  localparam logic [7:0] OFS_TOFS_LO   = 8'h20;
  localparam logic [7:0] OFS_TOFS_UP   = 8'h24;
  localparam logic [7:0] OFS_TOFS_HIGH = 8'h28;
  localparam logic [7:0] OFS_CNTEN     = 8'h30;
  // Field positions
  localparam int unsigned ENV_IO_FENCE_BIT  = 0;
  localparam int unsigned ENV_HW_AD_BIT     = 61;
  localparam int unsigned ENV_PAGE_TYPE_BIT = 62;
  localparam int unsigned CNT_CYCLE_BIT = 0;
  localparam int unsigned CNT_TIME_BIT  = 1;
  localparam int unsigned CNT_INSTR_BIT = 2;
  // Reset values
  localparam logic [63:0] RST_ENV   = 64'h0;
  localparam logic [63:0] RST_TOFS  = 64'h0;
  localparam logic [63:0] RST_EN    = 64'h0;
  localparam logic [31:0] RST_CNTEN = 32'h0;

  // Byte-lane merge of a bus write into one 32-bit word
  function automatic logic [31:0] hgcb_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return res;
  endfunction : hgcb_merge
endpackage : hgcb_pkg
